// *** hw/pfd_main_div.sv ***
// Purpose: main-loop programmable divider with toggle prescaler
// Assumes: i_edge is a one-cycle pulse per rising loop-input edge
// Notes: division factor 10 to 30
`timescale 1ns/1ns
module pfd_main_div (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // loop edge and factor
   input wire logic i_edge,
   input wire logic [4:0] i_factor,
   // divided output
   output logic o_div
);
   import pfd_pkg::*;

   typedef struct packed {
      logic prescale_toggle_ff;
      logic reload_latch_ff;
      logic [3:0] main_down_counter;
      logic div;
   } pfd_main_s;

   pfd_main_s st;
   pfd_main_s next_st;
   logic reload_req;

   // reload decoded from all four count bits (count of two)
   assign reload_req = (st.main_down_counter[3:1] == PFD_MAIN_RELOAD_CNT[3:1]) && !st.main_down_counter[0];

   always_comb begin
      next_st = st;
      next_st.div = 1'b0;
      if (i_rst) begin
         next_st.prescale_toggle_ff = i_factor[PFD_M_MSB];
         next_st.main_down_counter = i_factor[3:0];
         next_st.reload_latch_ff = 1'b0;
         next_st.div = 1'b0;
      end else if (i_edge) begin
         if (st.reload_latch_ff) begin
            next_st.main_down_counter = i_factor[3:0];
            next_st.prescale_toggle_ff = i_factor[PFD_M_MSB];
            next_st.reload_latch_ff = 1'b0;
            next_st.div = 1'b1;
         end else begin
            next_st.prescale_toggle_ff = ~st.prescale_toggle_ff;
            if (st.prescale_toggle_ff) begin
               next_st.main_down_counter = st.main_down_counter - 4'h1;
            end
            next_st.reload_latch_ff = reload_req;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      st <= next_st;
   end

   assign o_div = st.div;
endmodule // pfd_main_div

// *** hw/pfd_pkg.sv ***
// Purpose: shared constants and carriers for the loop feedback dividers
// Assumes: one 20 MHz reference clock, loop inputs sampled synchronously
// Notes: the divider counts advance on sampled rising edges of i_main_loop_in and i_ref_loop_in
package pfd_pkg;
   localparam int unsigned PFD_CLK_HZ = 20000000;
   localparam int unsigned PFD_OVER_MS = 3;
   localparam int unsigned PFD_SHORT_MS = 4;
   localparam int unsigned PFD_OVER_CYC = PFD_CLK_HZ / 1000 * PFD_OVER_MS;
   localparam int unsigned PFD_SHORT_CYC = PFD_CLK_HZ / 1000 * PFD_SHORT_MS;
   localparam int unsigned PFD_TMR_W = 20;
   localparam logic [3:0] PFD_MAIN_RELOAD_CNT = 4'h2;
   localparam logic [3:0] PFD_REF_LATCH_CNT = 4'h3;
   localparam logic [3:0] PFD_REF_LOAD_CNT = 4'h1;
   localparam logic [3:0] PFD_STAGE_ZERO = 4'h0;
   localparam int unsigned PFD_M_MSB = 4;
   localparam int unsigned PFD_REF_W = 12;

   typedef enum logic [1:0] {
      PFD_LK_TRACK = 2'b00,
      PFD_LK_OVER = 2'b01,
      PFD_LK_SHORT = 2'b10
   } pfd_lock_e;

   // band select lines: sub-range a, b and oscillator c
   typedef struct packed {
      logic osc_hi;
      logic sub_b;
      logic sub_a;
   } pfd_band_s;

   // range control lines on the first output port
   typedef struct packed {
      logic slow_am;
      logic doubler_on;
      logic mixer_on;
      logic lowpass_260;
   } pfd_range_s;

   // output ports of the setting expander
   typedef struct packed {
      logic [PFD_REF_W-1:0] ref_factor;
      logic [4:0] main_factor;
      pfd_band_s band;
      pfd_range_s range;
   } pfd_setting_s;
endpackage

// *** hw/pfd_ref_div.sv ***
// Purpose: reference-loop 12-bit cascaded divider with reload latches
// Assumes: i_edge is a one-cycle pulse per rising loop-input edge
// Notes: three 4-bit stages, lsb in the lowest
`timescale 1ns/1ns
module pfd_ref_div (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // loop edge and factor
   input wire logic i_edge,
   input wire logic [11:0] i_factor,
   // divided output
   output logic o_div
);
   import pfd_pkg::*;

   typedef struct packed {
      logic [11:0] cnt;
      logic latch1;
      logic latch2;
      logic div;
   } pfd_ref_s;

   pfd_ref_s st;
   pfd_ref_s next_st;
   logic [2:0] stage_zero;
   logic upper_borrow;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_stage
         assign stage_zero[g] = (st.cnt[g*4 +: 4] == PFD_STAGE_ZERO);
      end
   endgenerate

   // upper two stages both at zero; the lowest stage is compared at the latch checks
   assign upper_borrow = stage_zero[2] && stage_zero[1];

   always_comb begin
      next_st = st;
      next_st.div = 1'b0;
      if (i_rst) begin
         next_st.cnt = i_factor;
         next_st.latch1 = 1'b0;
         next_st.latch2 = 1'b0;
         next_st.div = 1'b0;
      end else if (i_edge) begin
         if (st.latch2) begin
            next_st.cnt = i_factor;
            next_st.latch2 = 1'b0;
            next_st.latch1 = 1'b0;
            next_st.div = 1'b1;
         end else begin
            next_st.cnt = st.cnt - 12'h001;
            if (upper_borrow && st.cnt[3:0] == PFD_REF_LATCH_CNT) begin
               next_st.latch1 = 1'b1;
            end
            if (st.latch1 && st.cnt[3:0] == PFD_REF_LOAD_CNT + 4'h1) begin
               next_st.latch2 = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      st <= next_st;
   end

   assign o_div = st.div;
endmodule // pfd_ref_div

// *** hw/pfd_top.sv ***
// Purpose: digital part of the main and reference phase-locked loops
// Assumes: all inputs but i_arst_n synchronous to i_ref_clk (20 MHz)
// Notes: analog parts are outside; their switch lines are outputs here
//
// Operation
// - main counter counts down to two
// - five-bit factor, msb presets prescaler
// - prescaler halves clock into main counter
// - main divider updates on rising edges only
// - reload decoded from all four count bits
// - count two sets reload latch next edge
// - reload latch loads counter and prescaler
// - latch clears next edge, countdown restarts
// - edge phase detector, duty shows difference
// - loop sense inverted on lower-sideband bands
// - over limit 3 ms shorts loop 4 ms
// - band lines decode one-of-four preset voltage
// - gain resistors by factor, sensitivity by band
// - twelve-bit reference factor, lsb lowest stage
// - upper stages borrow at zero
// - count three captured into first latch
// - count one: second latch loads all
// - expander takes data, holds on outputs
// - four range controls on first port
// - range controls encoded by frequency range
// - band lines: sub-range, then oscillator select
`timescale 1ns/1ns
module pfd_top (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_sync_rst,
   // setting expander input
   input wire logic i_set_we,
   input wire pfd_pkg::pfd_setting_s i_set_data,
   // loop inputs
   input wire logic i_main_loop_in,
   input wire logic i_main_ref_in,
   input wire logic i_ref_loop_in,
   input wire logic i_integ_over,
   // phase detector and loop control
   output logic o_pd_up,
   output logic o_pd_down,
   output logic o_sense_invert,
   output logic o_loop_short,
   // tuning selections
   output logic [3:0] o_osc1_preset_sel,
   output logic [3:0] o_osc2_preset_sel,
   output logic o_osc_hi_sel,
   output logic [4:0] o_gain_sel,
   output logic [2:0] o_sens_sel,
   // range controls and divided outputs
   output pfd_pkg::pfd_range_s o_range,
   output logic o_main_div,
   output logic o_ref_div
);
   import pfd_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] rst_sync;
      pfd_setting_s setting_port_expander;
      logic [2:0] main_in_d;
      logic [1:0] mref_in_d;
      logic ref_in_d;
      logic pd_up;
      logic pd_down;
      pfd_lock_e lk;
      logic [PFD_TMR_W-1:0] tmr;
      logic sense_invert;
      logic loop_short;
      logic [3:0] osc1_sel;
      logic [3:0] osc2_sel;
      logic osc_hi;
      logic [4:0] gain_sel;
      logic [2:0] sens_sel;
      pfd_range_s range;
      logic main_div_q;
      logic ref_div_q;
   } pfd_top_s;

   pfd_top_s st;
   pfd_top_s next_st;
   logic rst;
   logic main_edge;
   logic mref_edge;
   logic ref_edge;
   logic main_div;
   logic ref_div;

   assign rst = st.rst_sync[1] | i_sync_rst;
   assign main_edge = st.main_in_d[1] & ~st.main_in_d[2];
   assign mref_edge = i_main_ref_in & ~st.mref_in_d[0];
   assign ref_edge = i_ref_loop_in & ~st.ref_in_d;

   // ---------------------------------------------------------------
   // dividers
   // ---------------------------------------------------------------
   pfd_main_div u_main_div (
      .i_ref_clk(i_ref_clk),
      .i_rst(rst),
      .i_edge(main_edge),
      .i_factor(st.setting_port_expander.main_factor),
      .o_div(main_div)
   );

   pfd_ref_div u_ref_div (
      .i_ref_clk(i_ref_clk),
      .i_rst(rst),
      .i_edge(ref_edge),
      .i_factor(st.setting_port_expander.ref_factor),
      .o_div(ref_div)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.rst_sync = {st.rst_sync[0], 1'b0};
      next_st.main_in_d = {st.main_in_d[1:0], i_main_loop_in};
      next_st.mref_in_d = {st.mref_in_d[0], i_main_ref_in};
      next_st.ref_in_d = i_ref_loop_in;
      next_st.main_div_q = main_div;
      next_st.ref_div_q = ref_div;
      if (i_set_we) begin
         next_st.setting_port_expander = i_set_data;
      end
      // edge phase detector
      if (main_div && mref_edge) begin
         next_st.pd_up = 1'b0;
         next_st.pd_down = 1'b0;
      end else if (mref_edge) begin
         if (st.pd_down) begin
            next_st.pd_down = 1'b0;
         end else begin
            next_st.pd_up = 1'b1;
         end
      end else if (main_div) begin
         if (st.pd_up) begin
            next_st.pd_up = 1'b0;
         end else begin
            next_st.pd_down = 1'b1;
         end
      end
      // loop sense: lower sideband on sub-ranges 00 and 01
      next_st.sense_invert = ~st.setting_port_expander.band.sub_b;
      // band decoding
      next_st.osc_hi = st.setting_port_expander.band.osc_hi;
      next_st.osc1_sel = 4'h0;
      next_st.osc2_sel = 4'h0;
      if (st.setting_port_expander.band.osc_hi) begin
         next_st.osc2_sel[{st.setting_port_expander.band.sub_b, st.setting_port_expander.band.sub_a}] = 1'b1;
      end else begin
         next_st.osc1_sel[{st.setting_port_expander.band.sub_b, st.setting_port_expander.band.sub_a}] = 1'b1;
      end
      next_st.gain_sel = st.setting_port_expander.main_factor;
      next_st.sens_sel = st.setting_port_expander.band;
      next_st.range = st.setting_port_expander.range;
      // lock-in recovery timer
      case (st.lk)
         PFD_LK_TRACK: begin
            next_st.tmr = '0;
            next_st.loop_short = 1'b0;
            if (i_integ_over) begin
               next_st.lk = PFD_LK_OVER;
            end
         end
         PFD_LK_OVER: begin
            next_st.tmr = st.tmr + 1'b1;
            if (!i_integ_over) begin
               next_st.lk = PFD_LK_TRACK;
            end else if (st.tmr == PFD_TMR_W'(PFD_OVER_CYC - 1)) begin
               next_st.lk = PFD_LK_SHORT;
               next_st.tmr = '0;
               next_st.loop_short = 1'b1;
            end
         end
         PFD_LK_SHORT: begin
            next_st.tmr = st.tmr + 1'b1;
            if (st.tmr == PFD_TMR_W'(PFD_SHORT_CYC - 1)) begin
               next_st.lk = PFD_LK_TRACK;
               next_st.loop_short = 1'b0;
               next_st.tmr = '0;
            end
         end
         default: begin
            next_st.lk = PFD_LK_TRACK;
         end
      endcase
      if (rst) begin
         next_st.lk = PFD_LK_TRACK;
         next_st.tmr = '0;
         next_st.loop_short = 1'b0;
         next_st.pd_up = 1'b0;
         next_st.pd_down = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '0;
         st.rst_sync <= 2'h3;
      end else begin
         st <= next_st;
      end
   end

   assign o_pd_up = st.pd_up;
   assign o_pd_down = st.pd_down;
   assign o_sense_invert = st.sense_invert;
   assign o_loop_short = st.loop_short;
   assign o_osc1_preset_sel = st.osc1_sel;
   assign o_osc2_preset_sel = st.osc2_sel;
   assign o_osc_hi_sel = st.osc_hi;
   assign o_gain_sel = st.gain_sel;
   assign o_sens_sel = st.sens_sel;
   assign o_range = st.range;
   assign o_main_div = st.main_div_q;
   assign o_ref_div = st.ref_div_q;
endmodule // pfd_top

// *** test/pfd_proc_model.sv ***
// Purpose: processor side writing the setting expander
// Assumes: requests from the bench, one per write
// Notes: data lines toggle when not writing
`timescale 1ns/1ns
module pfd_proc_model (
   // clock
   input wire logic i_ref_clk,
   // bench request
   input wire logic i_req,
   input wire pfd_pkg::pfd_setting_s i_req_data,
   // expander write
   output logic o_set_we,
   output pfd_pkg::pfd_setting_s o_set_data
);
   import pfd_pkg::*;
   pfd_setting_s v;
   initial o_set_we = 1'b0;
   initial o_set_data = '0;
   always @(posedge i_ref_clk) begin
      v = i_req_data;
      if (v.main_factor < 5'h0a || v.main_factor > 5'h1e) begin
         v.main_factor = 5'h0a;
      end
      o_set_we <= i_req;
      if (i_req) begin
         o_set_data <= v;
      end else begin
         o_set_data <= ~o_set_data;
      end
   end
endmodule // pfd_proc_model

// *** test/pfd_top_asserts.sv ***
// Purpose: port checks for the loop divider top
// Assumes: one clock, async active-low reset
// Notes: bound to pfd_top below
`timescale 1ns/1ns
module pfd_top_chk (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // watched inputs
   input wire logic i_set_we,
   input wire pfd_pkg::pfd_setting_s i_set_data,
   input wire logic i_integ_over,
   // watched outputs
   input wire logic o_pd_up,
   input wire logic o_pd_down,
   input wire logic o_sense_invert,
   input wire logic o_loop_short,
   input wire logic [3:0] o_osc1_preset_sel,
   input wire logic [3:0] o_osc2_preset_sel,
   input wire logic o_osc_hi_sel,
   input wire logic [4:0] o_gain_sel,
   input wire logic [2:0] o_sens_sel,
   input wire pfd_pkg::pfd_range_s o_range,
   input wire logic o_main_div,
   input wire logic o_ref_div
);
   import pfd_pkg::*;
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   a_sense_band: assert property (i_set_we |-> ##2 o_sense_invert == !$past(i_set_data.band.sub_b, 2))
      else $error("sense select wrong");
   a_osc_select: assert property (i_set_we |-> ##2 o_osc_hi_sel == $past(i_set_data.band.osc_hi, 2))
      else $error("oscillator select wrong");
   a_range_hold: assert property (i_set_we |-> ##2 o_range == $past(i_set_data.range, 2))
      else $error("range lines wrong");
   a_gain_factor: assert property (i_set_we |-> ##2 o_gain_sel == $past(i_set_data.main_factor, 2))
      else $error("gain select wrong");
   a_sens_band: assert property (i_set_we |-> ##2 o_sens_sel == $past(i_set_data.band, 2))
      else $error("sensitivity select wrong");
   a_preset_onehot: assert property ($onehot0(o_osc1_preset_sel) && $onehot0(o_osc2_preset_sel)
      && (o_osc_hi_sel ? o_osc1_preset_sel == 4'h0 : o_osc2_preset_sel == 4'h0))
      else $error("preset select not one of four");
   a_short_hold: assert property ($rose(o_loop_short) |-> o_loop_short[*8])
      else $error("short too brief");
   a_short_cause: assert property ($rose(o_loop_short) |-> $past(i_integ_over))
      else $error("short without over limit");
   a_pd_excl: assert property (!(o_pd_up && o_pd_down))
      else $error("detector drives both ways");
   a_main_pulse: assert property (o_main_div |=> !o_main_div)
      else $error("main pulse too long");
   a_ref_pulse: assert property (o_ref_div |=> !o_ref_div)
      else $error("ref pulse too long");
   c_write: cover property (i_set_we ##2 o_sense_invert);
   c_short: cover property ($rose(o_loop_short));
   c_main: cover property (o_main_div);
   c_ref: cover property (o_ref_div);
endmodule // pfd_top_chk

bind pfd_top pfd_top_chk u_chk (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_set_we(i_set_we),
   .i_set_data(i_set_data), .i_integ_over(i_integ_over), .o_pd_up(o_pd_up), .o_pd_down(o_pd_down),
   .o_sense_invert(o_sense_invert), .o_loop_short(o_loop_short), .o_osc1_preset_sel(o_osc1_preset_sel),
   .o_osc2_preset_sel(o_osc2_preset_sel), .o_osc_hi_sel(o_osc_hi_sel), .o_gain_sel(o_gain_sel),
   .o_sens_sel(o_sens_sel), .o_range(o_range), .o_main_div(o_main_div), .o_ref_div(o_ref_div));

// *** test/tb_pll_feedback_dividers.sv ***
// Purpose: self-checking bench for pfd_top
// Assumes: 20 MHz clock, settings written by the processor model
// Notes: divider ratios checked as pulse counts
`timescale 1ns/1ns
module tb_pll_feedback_dividers;
   import pfd_pkg::*;
   logic ref_clk = 0, arst_n = 0, sync_rst = 0, req = 0;
   logic main_in = 0, mref_in = 0, rloop_in = 0, over = 0;
   logic set_we, pd_up, pd_dn, sense, lshort, osc_hi, mdiv, rdiv;
   logic [3:0] p1, p2;
   logic [4:0] gain;
   logic [2:0] sens;
   pfd_range_s rng;
   pfd_setting_s req_data = '0, set_data, s = '0;
   int n_fail = 0, total_checks = 0, cm = 0, cr = 0, cu = 0, cd = 0, w;
   logic [3:0] rtab [6] = '{4'ha, 4'h2, 4'h0, 4'h1, 4'h0, 4'h4};
   logic [4:0] mt [4] = '{5'h0a, 5'h0d, 5'h1e, 5'h13};
   logic [11:0] ft [4] = '{12'h003, 12'h00f, 12'h010, 12'hfff};
   // ----------------------------------------
   // clock, parts and tasks
   // ----------------------------------------
   initial forever #25 ref_clk = ~ref_clk;
   pfd_proc_model u_proc (.i_ref_clk(ref_clk), .i_req(req), .i_req_data(req_data), .o_set_we(set_we),
      .o_set_data(set_data));
   pfd_top dut (.i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_sync_rst(sync_rst), .i_set_we(set_we),
      .i_set_data(set_data), .i_main_loop_in(main_in), .i_main_ref_in(mref_in), .i_ref_loop_in(rloop_in),
      .i_integ_over(over), .o_pd_up(pd_up), .o_pd_down(pd_dn), .o_sense_invert(sense), .o_loop_short(lshort),
      .o_osc1_preset_sel(p1), .o_osc2_preset_sel(p2), .o_osc_hi_sel(osc_hi), .o_gain_sel(gain),
      .o_sens_sel(sens), .o_range(rng), .o_main_div(mdiv), .o_ref_div(rdiv));
   always @(negedge ref_clk) begin
      cm += int'(mdiv === 1'b1);
      cr += int'(rdiv === 1'b1);
      cu += int'(pd_up === 1'b1);
      cd += int'(pd_dn === 1'b1);
   end
   task automatic test_done;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_in(input string n, input int lo, input int hi, input int g);
      total_checks++;
      if (g < lo || g > hi) begin
         n_fail++;
         $display("FAIL %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask
   // main divider period in loop edges: count two arms the latch, the next edge reloads
   function automatic int main_period(input int m);
      int c = m % 16;
      int t = m / 16;
      int l = 0;
      int p = 0;
      while (p < 64) begin
         p++;
         if (l != 0) begin
            return p;
         end
         l = int'(c == 2);
         if (t != 0) begin
            c = (c + 15) % 16;
         end
         t = 1 - t;
      end
      return p;
   endfunction
   task automatic wr(input pfd_setting_s v);
      @(posedge ref_clk) begin
         req <= 1'b1;
         req_data <= v;
      end
      @(posedge ref_clk) req <= 1'b0;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic spin(input int n, input int pm, input int pr, input int pl);
      for (int c = 1; c <= n; c++) begin
         @(posedge ref_clk);
         if (c % pm == 0) main_in <= ~main_in;
         if (c % pr == 0) mref_in <= ~mref_in;
         if (c % pl == 0) rloop_in <= ~rloop_in;
      end
      @(negedge ref_clk);
   endtask
   task automatic div(input logic [4:0] m, input logic [11:0] f);
      s.main_factor = m;
      s.ref_factor = f;
      wr(s);
      @(posedge ref_clk) sync_rst <= 1'b1;
      @(posedge ref_clk) sync_rst <= 1'b0;
      @(negedge ref_clk);
      cm = 0;
      cr = 0;
      cu = 0;
      cd = 0;
      spin(960, 2, 400, 2);
      chk_in("main pulses", 240 / main_period(m) - 1, 240 / main_period(m) + 1, cm);
      chk_in("ref pulses", 240 / (f + 1) - 1, 240 / f + 1, cr);
      chk("pd down", 1, cd > cu);
   endtask
   initial begin
      #5000000;
      n_fail++;
      test_done;
   end
   initial begin
      void'($urandom(29));
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("short after reset", 0, lshort);
      for (int i = 0; i < 8; i++) begin
         s.band = 3'(i);
         s.range = rtab[i % 6];
         s.main_factor = 5'(10 + $urandom_range(20));
         s.ref_factor = 12'($urandom);
         wr(s);
         chk("sense", !s.band.sub_b, sense);
         chk("osc hi", s.band.osc_hi, osc_hi);
         chk("osc1 sel", s.band.osc_hi ? 4'h0 : 4'h1 << s.band[1:0], p1);
         chk("osc2 sel", s.band.osc_hi ? 4'h1 << s.band[1:0] : 4'h0, p2);
         chk("gain", s.main_factor, gain);
         chk("sens", s.band, sens);
         chk("range", s.range, rng);
      end
      for (int i = 0; i < 4; i++) div(mt[i], ft[i]);
      cu = 0;
      cd = 0;
      spin(960, 3, 2, 2);
      chk("pd up", 1, cu > cd);
      @(posedge ref_clk) over <= 1'b1;
      repeat (20000) @(posedge ref_clk);
      over <= 1'b0;
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("early short", 0, lshort);
      @(posedge ref_clk) over <= 1'b1;
      repeat (59900) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("short too soon", 0, lshort);
      w = 0;
      while (lshort !== 1'b1 && w < 300) begin
         @(negedge ref_clk);
         w++;
      end
      chk("short on", 1, lshort);
      test_done;
   end
endmodule // tb_pll_feedback_dividers
